// file: rtl/upf_ctrl.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module upf_ctrl
    import upf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [UPF_AW-1:0] reg_addr,
    input wire logic [UPF_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [UPF_DW-1:0] reg_rdata,
    // Strap pin, asynchronous
    input wire logic drive_strength_strap_pin,
    // Lookup-miss request and decision
    input wire upf_miss_s miss_req,
    output upf_fwd_s fwd_rsp,
    // Egress self-address check
    input wire upf_egr_s egr_req,
    input wire logic [UPF_MW-1:0] own_mac,
    output logic egr_done,
    output logic egr_drop,
    // Pad drive control
    output logic [1:0] drive_sel,
    output logic [3:0] drive_ma
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [1:0] drive_sel_r; // Pad drive select
    logic umc_en_r; // Unknown multicast enable
    logic [UPF_PW-1:0] umc_map_r; // Unknown multicast map
    logic uvid_en_r; // Unknown VLAN enable
    logic [UPF_PW-1:0] uvid_map_r; // Unknown VLAN map
    logic self_en_r; // Self-address filter enable
    logic ipmc_en_r; // Unknown IP multicast enable
    logic [UPF_PW-1:0] ipmc_map_r; // Unknown IP multicast map
    logic [UPF_DW-1:0] rdata_r; // Read data, one cycle late
    logic [3:0] drive_ma_r; // Drive current in mA
    upf_fwd_s fwd_r; // Registered decision
    logic egr_done_r;
    logic egr_drop_r;
    // Strap capture
    logic strap_s1_r;
    logic strap_s2_r;
    logic [1:0] strap_cnt_r;
    logic strap_done_r;
    // Write hits
    logic wr_drv;
    logic wr_uvid;
    logic wr_self;

    assign wr_drv = reg_wr && (reg_addr == UPF_OFS_DRV_UMC);
    assign wr_uvid = reg_wr && (reg_addr == UPF_OFS_UVID);
    assign wr_self = reg_wr && (reg_addr == UPF_OFS_SELF_IPMC);

    // ------------------------------------------------------------
    // Strap synchroniser
    // ------------------------------------------------------------
    // Pin is asynchronous; only the second stage is read
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_s1_r <= 1'b1;
            strap_s2_r <= 1'b1;
        end
        else
        begin
            strap_s1_r <= drive_strength_strap_pin;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Wait until the synchroniser holds a true pin sample
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
        end
        else if (strap_cnt_r != UPF_STRAP_WAIT)
        begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
        else
        begin
            strap_done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Drive select and unknown multicast register
    // ------------------------------------------------------------
    // A software write in the load cycle wins over the strap
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            drive_sel_r <= UPF_DRV_RST;
            umc_en_r <= UPF_EN_RST;
            umc_map_r <= UPF_MAP_RST;
        end
        else if (wr_drv)
        begin
            drive_sel_r <= reg_wdata[UPF_DRV_HI:UPF_DRV_LO];
            umc_en_r <= reg_wdata[UPF_EN_BIT];
            umc_map_r <= reg_wdata[UPF_PW-1:0];
        end
        else if ((strap_cnt_r == UPF_STRAP_WAIT) && !strap_done_r)
        begin
            drive_sel_r <= {~strap_s2_r, strap_s2_r};
        end
    end

    // Current code for the pads
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            drive_ma_r <= UPF_MA_1;
        end
        else
        begin
            case (drive_sel_r)
                2'h0: drive_ma_r <= UPF_MA_0;
                2'h1: drive_ma_r <= UPF_MA_1;
                2'h2: drive_ma_r <= UPF_MA_2;
                default: drive_ma_r <= UPF_MA_3;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Unknown VLAN, self filter and IP multicast registers
    // ------------------------------------------------------------
    // Reserved bits are not stored, so writes to them vanish
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            uvid_en_r <= UPF_EN_RST;
            uvid_map_r <= UPF_MAP_RST;
        end
        else if (wr_uvid)
        begin
            uvid_en_r <= reg_wdata[UPF_EN_BIT];
            uvid_map_r <= reg_wdata[UPF_PW-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            self_en_r <= UPF_EN_RST;
            ipmc_en_r <= UPF_EN_RST;
            ipmc_map_r <= UPF_MAP_RST;
        end
        else if (wr_self)
        begin
            self_en_r <= reg_wdata[UPF_SELF_BIT];
            ipmc_en_r <= reg_wdata[UPF_EN_BIT];
            ipmc_map_r <= reg_wdata[UPF_PW-1:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r <= 8'h00;
        end
        else if (!reg_rd)
        begin
            rdata_r <= 8'h00;
        end
        else if (reg_addr == UPF_OFS_DRV_UMC)
        begin
            rdata_r <= {drive_sel_r, umc_en_r, umc_map_r};
        end
        else if (reg_addr == UPF_OFS_UVID)
        begin
            rdata_r <= {2'h0, uvid_en_r, uvid_map_r};
        end
        else if (reg_addr == UPF_OFS_SELF_IPMC)
        begin
            rdata_r <= {1'b0, self_en_r, ipmc_en_r, ipmc_map_r};
        end
        else
        begin
            rdata_r <= 8'h00; // Unmapped reads zero
        end
    end

    // ------------------------------------------------------------
    // Lookup-miss forwarding decision
    // ------------------------------------------------------------
    // Disabled class falls back to plain flooding to all ports
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fwd_r <= '0;
        end
        else
        begin
            fwd_r.valid <= miss_req.valid;
            fwd_r.drop <= 1'b0;
            fwd_r.map <= UPF_MAP_ALL;
            case (miss_req.cls)
                UPF_CLS_UMC:
                begin
                    if (umc_en_r)
                    begin
                        fwd_r.map <= umc_map_r;
                        fwd_r.drop <= (umc_map_r == 5'h00);
                    end
                end
                UPF_CLS_UVID:
                begin
                    if (uvid_en_r)
                    begin
                        fwd_r.map <= uvid_map_r;
                        fwd_r.drop <= (uvid_map_r == 5'h00);
                    end
                end
                UPF_CLS_UIPMC:
                begin
                    if (ipmc_en_r)
                    begin
                        fwd_r.map <= ipmc_map_r;
                        fwd_r.drop <= (ipmc_map_r == 5'h00);
                    end
                end
                default:
                begin
                    fwd_r.valid <= 1'b0; // Illegal class ignored
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Egress self-address filter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            egr_done_r <= 1'b0;
            egr_drop_r <= 1'b0;
        end
        else
        begin
            egr_done_r <= egr_req.valid;
            // Exact match covers unicast and multicast alike
            egr_drop_r <= egr_req.valid && self_en_r
                && (egr_req.da == own_mac);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign fwd_rsp = fwd_r;
    assign egr_done = egr_done_r;
    assign egr_drop = egr_drop_r;
    assign drive_sel = drive_sel_r;
    assign drive_ma = drive_ma_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_drive_ma_map: assert property (
        drive_sel_r == 2'h2 |=> drive_ma_r == 4'hA)
        else $error("drive code 10 not 10 mA");
    a_strap_load_val: assert property (
        $rose(strap_done_r) && !$past(wr_drv)
        |-> drive_sel_r == {~$past(strap_s2_r), $past(strap_s2_r)})
        else $error("strap load wrong");
    a_umc_map_use: assert property (
        miss_req.valid && miss_req.cls == UPF_CLS_UMC && umc_en_r
        |=> fwd_r.valid && fwd_r.map == $past(umc_map_r))
        else $error("multicast map not applied");
    a_umc_drop_zero: assert property (
        miss_req.valid && miss_req.cls == UPF_CLS_UMC && umc_en_r
        && umc_map_r == 5'h00 |=> fwd_r.drop)
        else $error("multicast zero map not dropped");
    a_uvid_map_use: assert property (
        miss_req.valid && miss_req.cls == UPF_CLS_UVID && uvid_en_r
        |=> fwd_r.map == $past(uvid_map_r)
        && fwd_r.drop == ($past(uvid_map_r) == 5'h00))
        else $error("vlan map not applied");
    a_ipmc_map_use: assert property (
        miss_req.valid && miss_req.cls == UPF_CLS_UIPMC && ipmc_en_r
        |=> fwd_r.map == $past(ipmc_map_r)
        && fwd_r.drop == ($past(ipmc_map_r) == 5'h00))
        else $error("ip multicast map not applied");
    a_self_drop_hit: assert property (
        egr_req.valid && self_en_r && egr_req.da == own_mac
        |=> egr_done_r && egr_drop_r)
        else $error("self frame not dropped");
    a_self_pass_off: assert property (
        !self_en_r |=> !egr_drop_r)
        else $error("drop while filter off");
    a_rsvd_read_zero: assert property (
        reg_rd && reg_addr == UPF_OFS_SELF_IPMC |=> !reg_rdata[7])
        else $error("reserved bit not zero");
    a_wr_rd_back: assert property (
        wr_uvid ##1 (reg_rd && reg_addr == UPF_OFS_UVID)
        |=> reg_rdata == {2'h0, $past(reg_wdata, 2) & 8'h3F})
        else $error("vlan register read back wrong");

    c_umc_drop: cover property (fwd_r.valid && fwd_r.drop);
    c_self_drop: cover property (egr_drop_r);
    c_strap_low: cover property ($rose(strap_done_r) && drive_sel_r == 2'h2);
endmodule // upf_ctrl

// file: rtl/upf_pkg.sv
package upf_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned UPF_AW = 8;  // Register address width
    localparam int unsigned UPF_DW = 8;  // Register data width
    localparam int unsigned UPF_PW = 5;  // Port map width, one bit per port
    localparam int unsigned UPF_MW = 48; // MAC address width

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] UPF_OFS_DRV_UMC = 8'h84;
    localparam logic [7:0] UPF_OFS_UVID = 8'h85;
    localparam logic [7:0] UPF_OFS_SELF_IPMC = 8'h86;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned UPF_DRV_HI = 7; // Drive select upper bit
    localparam int unsigned UPF_DRV_LO = 6; // Drive select lower bit
    localparam int unsigned UPF_EN_BIT = 5; // Forward enable in each register
    localparam int unsigned UPF_SELF_BIT = 6; // Self-address filter enable

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [1:0] UPF_DRV_RST = 2'h1;
    localparam logic [4:0] UPF_MAP_RST = 5'h00;
    localparam logic [4:0] UPF_MAP_ALL = 5'h1F;
    localparam logic UPF_EN_RST = 1'b0;
    localparam logic [1:0] UPF_STRAP_WAIT = 2'h2; // Synchroniser depth

    // ------------------------------------------------------------
    // Drive current in mA per select code
    // ------------------------------------------------------------
    localparam logic [3:0] UPF_MA_0 = 4'h4;
    localparam logic [3:0] UPF_MA_1 = 4'h8;
    localparam logic [3:0] UPF_MA_2 = 4'hA;
    localparam logic [3:0] UPF_MA_3 = 4'hE;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Class of a frame that missed the lookup
    typedef enum logic [2:0] {
        UPF_CLS_UMC = 3'b001,
        UPF_CLS_UVID = 3'b010,
        UPF_CLS_UIPMC = 3'b100
    } upf_cls_e;

    // Lookup-miss request from the forwarding engine
    typedef struct packed {
        logic valid;
        upf_cls_e cls;
    } upf_miss_s;

    // Forwarding decision back to the engine
    typedef struct packed {
        logic valid;
        logic drop;
        logic [UPF_PW-1:0] map;
    } upf_fwd_s;

    // Egress frame check request
    typedef struct packed {
        logic valid;
        logic [UPF_MW-1:0] da;
    } upf_egr_s;
endpackage

// file: sim/tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb;
    import upf_pkg::*;
    logic ref_clk;
    logic rstn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic strap; // Strap level driven in place of the pull-up
    logic [47:0] own_mac;
    upf_miss_s miss_req;
    upf_fwd_s fwd_rsp;
    upf_egr_s egr_req;
    logic egr_done;
    logic egr_drop;
    logic [1:0] drive_sel;
    logic [3:0] drive_ma;
    int errors;
    int checks_done;
    upf_fwd_s rsp; // Last decision seen
    logic done;
    logic drop;
    logic [7:0] ofs [3] = '{8'h84, 8'h85, 8'h86}; // Class registers
    logic [2:0] cls [3] = '{3'h1, 3'h2, 3'h4}; // Matching class codes
    logic [4:0] maps [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0A, 5'h1F};
    logic [3:0] ma [4] = '{4'h4, 4'h8, 4'hA, 4'hE}; // Current per code

    upf_ctrl i_upf_ctrl (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .drive_strength_strap_pin(strap), .miss_req(miss_req), .fwd_rsp(fwd_rsp),
        .egr_req(egr_req), .own_mac(own_mac), .egr_done(egr_done), .egr_drop(egr_drop),
        .drive_sel(drive_sel), .drive_ma(drive_ma));
    upf_eng_model i_upf_eng_model (.ref_clk(ref_clk), .miss_req(miss_req),
        .fwd_rsp(fwd_rsp), .egr_req(egr_req), .egr_done(egr_done), .egr_drop(egr_drop));

    // 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    // Single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read strobe, data sampled in the one cycle it stands
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // Reset with a given strap level, then let the strap load settle
    task automatic do_reset(input logic s);
        rstn <= 1'b0;
        strap <= s;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask

    // Miss request against an expected decision
    task automatic mchk(input logic [2:0] c, input logic d, input logic [4:0] m);
        i_upf_eng_model.miss(c, rsp);
        chk({rsp.valid, rsp.drop, rsp.map}, {1'b1, d, m});
    endtask

    task automatic end_sim();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog, far beyond the roughly 160 cycles the tests need
    initial
    begin
        #200000;
        errors++;
        end_sim();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        errors = 0;
        checks_done = 0;
        rstn = 1'b0;
        strap = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        own_mac = 48'h0A0B0C0D0E0F;
        // Strap low gives code 10, strap high gives 01
        do_reset(1'b0);
        chk({drive_sel, drive_ma}, {2'h2, 4'hA});
        rdc(8'h84, 8'h80);
        rdc(8'h85, 8'h00);
        rdc(8'h86, 8'h00);
        do_reset(1'b1);
        chk({drive_sel, drive_ma}, {2'h1, 4'h8});
        // Every drive code
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h84, 8'(c << 6));
            repeat (2) @(posedge ref_clk);
            #1 chk({drive_sel, drive_ma}, {2'(c), ma[c]});
        end
        // Reserved bits and an unmapped place
        wr(8'h85, 8'hFF);
        rdc(8'h85, 8'h3F);
        wr(8'h86, 8'hFF);
        rdc(8'h86, 8'h7F);
        wr(8'h87, 8'hFF);
        rdc(8'h87, 8'h00);
        // Each class: enabled maps, then disabled floods
        for (int k = 0; k < 3; k++)
        begin
            for (int j = 0; j < 6; j++)
            begin
                wr(ofs[k], {3'h1, maps[j]});
                mchk(cls[k], maps[j] == 5'h00, maps[j]);
            end
            wr(ofs[k], 8'h03);
            mchk(cls[k], 1'b0, 5'h1F);
        end
        // Class code that is not one-hot gets no answer
        i_upf_eng_model.miss(3'h3, rsp);
        chk(rsp.valid, 1'b0);
        // Self-address filter on egress
        wr(8'h86, 8'h40);
        i_upf_eng_model.egr(own_mac, done, drop);
        chk({done, drop}, 2'h3);
        i_upf_eng_model.egr(own_mac ^ 48'h1, done, drop);
        chk({done, drop}, 2'h2);
        wr(8'h86, 8'h00);
        i_upf_eng_model.egr(own_mac, done, drop);
        chk({done, drop}, 2'h2);
        end_sim();
    end
endmodule // tb

// file: sim/upf_eng_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Forwarding engine stand-in
// ----------------------------------------
module upf_eng_model
    import upf_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Lookup-miss side
    output upf_miss_s miss_req,
    input wire upf_fwd_s fwd_rsp,
    // Egress check side
    output upf_egr_s egr_req,
    input wire logic egr_done,
    input wire logic egr_drop
);
    // Idle requests from time zero
    initial
    begin
        miss_req = '0;
        egr_req = '0;
    end

    // One miss pulse; decision is only valid in the following cycle
    task automatic miss(input logic [2:0] cls, output upf_fwd_s rsp);
        @(posedge ref_clk);
        miss_req <= '{valid: 1'b1, cls: upf_cls_e'(cls)};
        @(posedge ref_clk);
        miss_req <= '0;
        #1 rsp = fwd_rsp;
    endtask

    // One egress pulse; address inverted after release so no stale match
    task automatic egr(input logic [47:0] da, output logic done, output logic drop);
        @(posedge ref_clk);
        egr_req <= '{valid: 1'b1, da: da};
        @(posedge ref_clk);
        egr_req <= '{valid: 1'b0, da: ~da};
        #1;
        done = egr_done;
        drop = egr_drop;
    endtask
endmodule // upf_eng_model
